//--- logic/cap_regs_pkg.sv
/*
 * Constants for the device status and link capabilities config registers:
 * offsets, field positions, reset values and fixed capability codes.
 * Assumes configuration accesses arrive dword addressed with byte enables.
 */
// How it works
// - Status bits 15:6 always read zero
// - Bit 5 high while nonposted requests outstanding
// - Bit 4 mirrors auxiliary power presence
// - Bit 3 sticky on unsupported request
// - Bit 2 sticky on fatal error
// - Bit 1 sticky on nonfatal error
// - Bit 0 sticky on correctable error
// - Port number field reads constant zero
// - Capability bits 23:18 always read zero
// - Common clock: deep exit from diag bits 20:18
// - Separate clocks: deep exit from diag bits 17:15
// - Common clock: light exit reports 011b
// - Separate clocks: light exit reports 100b
// - Active PM support field reads 11b
// - Widest lane count reads 00 0001b
// - Fastest lane rate reads 1h
// - Link control bit 6 selects reported latencies
`default_nettype none
package cap_regs_pkg;

	// Byte offsets in configuration space, plus link control and diag field bit positions
	localparam logic [11:0] DEV_STATE_FLAGS_OFS  = 12'h09a;
	localparam logic [11:0] LINK_ABILITY_OFS     = 12'h09c;
	localparam logic [11:0] LINK_CTRL_OFS        = 12'h0a0;
	localparam logic [11:0] DIAG_CTRL1_OFS       = 12'h0c4;
	localparam int          COMMON_CLK_BIT       = 6;
	localparam int          DIAG_A_LSB           = 18;
	localparam int          DIAG_B_LSB           = 15;

	// Dword-aligned address width and byte lane of the status half
	localparam int          DW_ADDR_W            = 10;
	localparam int          STATUS_LANE          = 2;
	localparam int          STATUS_SHIFT         = 16;

	// Device status layout
	localparam int          NP_OUT_BIT           = 5;
	localparam int          AUX_BIT              = 4;
	localparam int          ERR_FLAGS            = 4;
	localparam logic [15:0] DEV_STATE_RESET      = 16'h0000;

	// Link capabilities layout and fixed codes
	localparam int          PORT_LSB             = 24;
	localparam int          DEEP_LSB             = 15;
	localparam int          LIGHT_LSB            = 12;
	localparam int          PM_LSB               = 10;
	localparam int          WIDTH_LSB            = 4;
	localparam int          RATE_LSB             = 0;
	localparam logic [7:0]  PORT_NUMBER          = 8'h00;
	localparam logic [2:0]  LIGHT_EXIT_COMMON    = 3'h3;
	localparam logic [2:0]  LIGHT_EXIT_SEPARATE  = 3'h4;
	localparam logic [1:0]  ACTIVE_PM_CODE       = 2'h3;
	localparam logic [5:0]  LANE_COUNT_CODE      = 6'h01;
	localparam logic [3:0]  LANE_RATE_CODE       = 4'h1;

	// Reply path states
	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_SEND = 2'b10
	} rd_state_e;

endpackage
`default_nettype wire

//--- logic/status_evt_if.sv
/*
 * Interface carrying status events between the register front end,
 * the outstanding request tracker and the sticky error flags.
 * Assumes all parties run on one clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface status_evt_if;
	logic                                   np_issue;
	logic                                   np_done;
	logic                                   pending;
	logic [cap_regs_pkg::ERR_FLAGS-1:0]     err_set;
	logic [cap_regs_pkg::ERR_FLAGS-1:0]     err_clr;
	logic [cap_regs_pkg::ERR_FLAGS-1:0]     err_flags;

	modport front (
		output np_issue,
		output np_done,
		output err_set,
		output err_clr,
		input  pending,
		input  err_flags
	);
	modport tracker (
		input  np_issue,
		input  np_done,
		output pending
	);
	modport flags (
		input  err_set,
		input  err_clr,
		output err_flags
	);
endinterface
`default_nettype wire

//--- logic/np_tracker.sv
/*
 * Counts nonposted requests sent and not yet completed.
 * Assumes issue and done are one-cycle pulses; done without a
 * matching issue is ignored.
 */
`timescale 1ns/1ps
`default_nettype none
module np_tracker #(
	parameter int CNT_W = 8
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	// Events
	status_evt_if.tracker   evt
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             busy;
	} trk_s;

	trk_s st_q;
	trk_s st_d;

	if (CNT_W < 1 || CNT_W > 16) begin : g_chk
		$error("np_tracker: CNT_W out of range");
	end

	always_comb begin
		st_d = st_q;
		if (evt.np_issue && !evt.np_done && st_q.cnt != {CNT_W{1'b1}}) begin
			st_d.cnt = st_q.cnt + 1'b1;
		end else if (!evt.np_issue && evt.np_done && st_q.cnt != '0) begin
			st_d.cnt = st_q.cnt - 1'b1;
		end
		st_d.busy = (st_d.cnt != '0);
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign evt.pending = st_q.busy;
endmodule
`default_nettype wire

//--- logic/err_flags.sv
/*
 * Sticky error detection flags, set by hardware and cleared by
 * writing one. Assumes set and clear arrive as one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module err_flags (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	// Events
	status_evt_if.flags     evt
);
	typedef struct packed {
		logic [cap_regs_pkg::ERR_FLAGS-1:0] flag;
	} flg_s;

	flg_s st_q;
	flg_s st_d;

	always_comb begin
		st_d = st_q;
		for (int i = 0; i < cap_regs_pkg::ERR_FLAGS; i++) begin
			// Set wins over a clear in the same cycle
			if (evt.err_set[i]) begin
				st_d.flag[i] = 1'b1;
			end else if (evt.err_clr[i]) begin
				st_d.flag[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign evt.err_flags = st_q.flag;
endmodule
`default_nettype wire

//--- logic/dev_link_regs.sv
/*
 * Configuration register front end for the device status and link
 * capabilities registers. Decodes dword-addressed config reads and
 * writes, returns read data one cycle after the request, and routes
 * error and request events into the tracker and sticky flags.
 * Assumes requests are synchronous to ref_clk and at most one per cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module dev_link_regs #(
	parameter int NP_CNT_W = 8
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// Configuration access
	input  wire logic        cfg_rd,
	input  wire logic        cfg_wr,
	input  wire logic [9:0]  cfg_dw_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] cfg_rdata,
	output logic             cfg_rvalid,
	// Bridge events
	input  wire logic        np_issue,
	input  wire logic        np_done,
	input  wire logic        unsupported_req,
	input  wire logic        fatal_err,
	input  wire logic        nonfatal_err,
	input  wire logic        correctable_err,
	input  wire logic        aux_supply_present,
	// Link control and diagnostic fields
	input  wire logic        common_clk_cfg,
	input  wire logic [2:0]  diag_deep_exit_a,
	input  wire logic [2:0]  diag_deep_exit_b,
	// Status mirror for error reporting logic
	output logic      [15:0] device_state_flags
);
	if (NP_CNT_W < 1 || NP_CNT_W > 16) begin : g_chk
		$error("dev_link_regs: NP_CNT_W out of range");
	end

	status_evt_if evt ();

	np_tracker #(
		.CNT_W   (NP_CNT_W)
	) u_tracker (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.evt     (evt)
	);

	err_flags u_flags (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.evt     (evt)
	);

	// Dword holding a byte offset
	function automatic logic hits(input logic [9:0] dw, input logic [11:0] ofs);
		hits = (dw == ofs[11:2]);
	endfunction

	// Device status word from live inputs
	function automatic logic [15:0] status_word(
		input logic       np_out,
		input logic       aux,
		input logic [3:0] errs
	);
		logic [15:0] w;
		w                           = cap_regs_pkg::DEV_STATE_RESET;
		w[cap_regs_pkg::NP_OUT_BIT] = np_out;
		w[cap_regs_pkg::AUX_BIT]    = aux;
		w[cap_regs_pkg::ERR_FLAGS-1:0] = errs;
		status_word                 = w;
	endfunction

	// Link capabilities word for the current clocking setting
	function automatic logic [31:0] caps_word(
		input logic       common,
		input logic [2:0] dea,
		input logic [2:0] deb
	);
		logic [31:0] w;
		w                               = 32'h0000_0000;
		w[cap_regs_pkg::PORT_LSB +: 8]  = cap_regs_pkg::PORT_NUMBER;
		// Latency pair follows link control bit 6
		if (common) begin
			w[cap_regs_pkg::DEEP_LSB +: 3]  = dea;
			w[cap_regs_pkg::LIGHT_LSB +: 3] = cap_regs_pkg::LIGHT_EXIT_COMMON;
		end else begin
			w[cap_regs_pkg::DEEP_LSB +: 3]  = deb;
			w[cap_regs_pkg::LIGHT_LSB +: 3] = cap_regs_pkg::LIGHT_EXIT_SEPARATE;
		end
		w[cap_regs_pkg::PM_LSB +: 2]    = cap_regs_pkg::ACTIVE_PM_CODE;
		w[cap_regs_pkg::WIDTH_LSB +: 6] = cap_regs_pkg::LANE_COUNT_CODE;
		w[cap_regs_pkg::RATE_LSB +: 4]  = cap_regs_pkg::LANE_RATE_CODE;
		caps_word                       = w;
	endfunction

	typedef struct packed {
		cap_regs_pkg::rd_state_e rd_st;
		logic [31:0]             rdata;
		logic                    rvalid;
		logic [15:0]             status;
	} front_s;

	front_s st_q;
	front_s st_d;

	logic [15:0] status_now;
	logic [31:0] caps_now;
	logic        status_hit_wr;

	// Event routing
	always_comb begin
		evt.np_issue = np_issue;
		evt.np_done  = np_done;
		evt.err_set  = {unsupported_req, fatal_err, nonfatal_err, correctable_err};
		status_hit_wr = cfg_wr && hits(cfg_dw_addr, cap_regs_pkg::DEV_STATE_FLAGS_OFS)
			&& cfg_be[cap_regs_pkg::STATUS_LANE];
		// Write one clears; status sits in the upper half of its dword
		evt.err_clr  = status_hit_wr
			? cfg_wdata[cap_regs_pkg::STATUS_SHIFT +: cap_regs_pkg::ERR_FLAGS]
			: '0;
	end

	always_comb begin
		status_now = status_word(evt.pending, aux_supply_present, evt.err_flags);
		caps_now   = caps_word(common_clk_cfg, diag_deep_exit_a, diag_deep_exit_b);
	end

	// Read reply path
	always_comb begin
		st_d        = st_q;
		st_d.status = status_now;
		st_d.rvalid = 1'b0;
		case (st_q.rd_st)
			cap_regs_pkg::RD_IDLE: begin
				if (cfg_rd) begin
					st_d.rd_st  = cap_regs_pkg::RD_SEND;
					st_d.rvalid = 1'b1;
					if (hits(cfg_dw_addr, cap_regs_pkg::DEV_STATE_FLAGS_OFS)) begin
						st_d.rdata = {status_now, 16'h0000};
					end else if (hits(cfg_dw_addr, cap_regs_pkg::LINK_ABILITY_OFS)) begin
						st_d.rdata = caps_now;
					end else begin
						st_d.rdata = 32'h0000_0000;
					end
				end
			end
			cap_regs_pkg::RD_SEND: begin
				st_d.rd_st = cap_regs_pkg::RD_IDLE;
				st_d.rdata = 32'h0000_0000;
			end
			default: begin
				st_d.rd_st = cap_regs_pkg::RD_IDLE;
				st_d.rdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_q.rd_st  <= cap_regs_pkg::RD_IDLE;
			st_q.rdata  <= 32'h0000_0000;
			st_q.rvalid <= 1'b0;
			st_q.status <= cap_regs_pkg::DEV_STATE_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign cfg_rdata          = st_q.rdata;
	assign cfg_rvalid         = st_q.rvalid;
	assign device_state_flags = st_q.status;
endmodule
`default_nettype wire

//--- testbench/dlr_monitor.sv
/* Checker on the ports of dev_link_regs.
   Bound to every instance of it; one clock, async low reset. */
`timescale 1ns/1ps
`default_nettype none
module dlr_monitor #(parameter int NP_CNT_W = 8) (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rstn,
	// Configuration access
	input wire logic        cfg_rd,
	input wire logic        cfg_wr,
	input wire logic [9:0]  cfg_dw_addr,
	input wire logic [3:0]  cfg_be,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic        cfg_rvalid,
	// Events and link fields
	input wire logic        np_issue,
	input wire logic        np_done,
	input wire logic        unsupported_req,
	input wire logic        fatal_err,
	input wire logic        nonfatal_err,
	input wire logic        correctable_err,
	input wire logic        aux_supply_present,
	input wire logic        common_clk_cfg,
	input wire logic [2:0]  diag_deep_exit_a,
	input wire logic [2:0]  diag_deep_exit_b,
	input wire logic [15:0] device_state_flags
);
	logic [3:0] ev;
	logic [3:0] wclr;
	logic       rd_cap;
	assign ev = {unsupported_req, fatal_err, nonfatal_err, correctable_err};
	assign wclr = {4{cfg_wr && cfg_dw_addr == 10'h026 && cfg_be[2]}} & cfg_wdata[19:16];
	assign rd_cap = cfg_rd && !cfg_rvalid && cfg_dw_addr == 10'h027;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	a_reply_one_cycle: assert property (cfg_rvalid |-> $past(cfg_rd) ##1 !cfg_rvalid)
		else $error("read reply not a single cycle");
	a_rdata_idle_zero: assert property (!cfg_rvalid |-> cfg_rdata == 32'h0000_0000)
		else $error("read data not zero outside reply");
	a_caps_fixed: assert property (rd_cap |=> cfg_rvalid && cfg_rdata[31:18] == 14'h0000 && cfg_rdata[11:0] == 12'hc11)
		else $error("fixed capability fields wrong");
	a_light_exit: assert property (rd_cap |=> cfg_rdata[14:12] == ($past(common_clk_cfg) ? 3'h3 : 3'h4))
		else $error("light idle exit code wrong");
	a_deep_exit: assert property (rd_cap |=> cfg_rdata[17:15] == ($past(common_clk_cfg) ? $past(diag_deep_exit_a) : $past(diag_deep_exit_b)))
		else $error("deep idle exit field wrong");
	a_status_rsvd: assert property (device_state_flags[15:6] == 10'h000)
		else $error("reserved status bits set");
	a_aux_mirror: assert property ($past(rstn) |-> device_state_flags[4] == $past(aux_supply_present))
		else $error("aux presence not mirrored");
	a_nonposted_outstanding_raise: assert property (np_issue && !np_done |-> ##2 device_state_flags[5])
		else $error("pending bit not raised");
	a_err_set: assert property (ev != 4'h0 |-> ##2 (device_state_flags[3:0] & $past(ev, 2)) == $past(ev, 2))
		else $error("error flag not set");
	a_err_hold: assert property (($past(device_state_flags[3:0]) & ~device_state_flags[3:0] & ~$past(wclr, 2)) == 4'h0)
		else $error("error flag fell without clear");
endmodule
bind dev_link_regs dlr_monitor #(.NP_CNT_W(NP_CNT_W)) dlr_monitor_i (.*);
`default_nettype wire

//--- testbench/rc_model.sv
/* Root complex model issuing config reads and writes.
   Drives just after ref_clk rises; released lines show inverted values. */
`timescale 1ns/1ps
`default_nettype none
module rc_model (
	// Clock
	input wire logic    ref_clk,
	// Config requests
	output logic        cfg_rd,
	output logic        cfg_wr,
	output logic [9:0]  cfg_dw_addr,
	output logic [3:0]  cfg_be,
	output logic [31:0] cfg_wdata
);
	initial begin
		{cfg_rd, cfg_wr, cfg_be} = 6'h00;
		cfg_dw_addr = 10'h000;
		cfg_wdata = 32'h0000_0000;
	end
	// Read held for n edges
	task automatic rd(input logic [9:0] a, input int n);
		@(posedge ref_clk);
		#1;
		cfg_rd = 1'b1;
		cfg_dw_addr = a;
		repeat (n) @(posedge ref_clk);
		#1;
		cfg_rd = 1'b0;
		cfg_dw_addr = ~a;
	endtask
	// Ones in lane 2 clear error flags
	task automatic wr(input logic [3:0] be, input logic [31:0] d);
		@(posedge ref_clk);
		#1;
		cfg_wr = 1'b1;
		cfg_dw_addr = 10'h026;
		cfg_be = be;
		cfg_wdata = d;
		@(posedge ref_clk);
		#1;
		cfg_wr = 1'b0;
		cfg_be = ~be;
		cfg_wdata = ~d;
	endtask
endmodule
`default_nettype wire

//--- testbench/dev_link_regs_tb_top.sv
/* Self-checking bench for dev_link_regs.
   Needs the design, checker and root complex model compiled first. */
`timescale 1ns/1ps
`default_nettype none
module dev_link_regs_tb_top;
	logic        ref_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        cfg_rd, cfg_wr, cfg_rvalid, np_issue, np_done;
	logic        aux_supply_present, common_clk_cfg;
	logic [9:0]  cfg_dw_addr;
	logic [3:0]  cfg_be, ev, errs;
	logic [2:0]  dea, deb;
	logic [15:0] device_state_flags;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic [31:0] rnd = 32'h0001_77ac;
	logic [31:0] exp_q[$];
	logic [5:0]  np_seq [6] = '{6'h20, 6'h24, 6'h10, 6'h10, 6'h10, 6'h30};
	int          n_mismatch = 0, n_compared = 0, np_cnt = 0, cyc = 0;
	always #50 ref_clk = ~ref_clk;
	dev_link_regs dev_link_regs_i (
		.ref_clk, .rstn, .cfg_rd, .cfg_wr, .cfg_dw_addr, .cfg_be, .cfg_wdata,
		.cfg_rdata, .cfg_rvalid, .np_issue, .np_done,
		.unsupported_req(ev[3]), .fatal_err(ev[2]), .nonfatal_err(ev[1]),
		.correctable_err(ev[0]), .aux_supply_present, .common_clk_cfg,
		.diag_deep_exit_a(dea), .diag_deep_exit_b(deb), .device_state_flags
	);
	rc_model rc_model_i (.ref_clk, .cfg_rd, .cfg_wr, .cfg_dw_addr, .cfg_be, .cfg_wdata);
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [31:0] st();
		return {10'h000, np_cnt != 0, aux_supply_present, errs, 16'h0000};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, seen, want);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] e, input int n);
		exp_q.push_back(e);
		rc_model_i.rd(a, n);
	endtask
	task automatic wr(input logic [3:0] be, input logic [31:0] d);
		if (be[2]) begin
			errs &= ~d[19:16];
		end
		rc_model_i.wr(be, d);
	endtask
	task automatic pulse(input logic [5:0] v);
		@(posedge ref_clk);
		#1;
		{np_issue, np_done, ev} = v;
		@(posedge ref_clk);
		#1;
		{np_issue, np_done, ev} = 6'h00;
		errs |= v[3:0];
		if (v[5] && !v[4] && np_cnt < 255) np_cnt++;
		if (v[4] && !v[5] && np_cnt > 0) np_cnt--;
	endtask
	always @(posedge ref_clk) begin
		if (cfg_rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				n_mismatch++;
				$display("BAD %0t reply without request", $time);
			end else begin
				chk(cfg_rdata, exp_q.pop_front());
			end
		end
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc > 3000) begin
			n_mismatch++;
			$display("BAD %0t timeout", $time);
			results();
		end
	end
	initial begin
		{np_issue, np_done, ev, aux_supply_present, common_clk_cfg, dea, deb} = 14'h0000;
		errs = 4'h0;
		repeat (2) @(posedge ref_clk);
		#1;
		rstn = 1'b1;
		chk({16'h0000, device_state_flags}, 32'h0000_0000);
		rd(10'h026, st(), 1);
		for (int i = 0; i < 8; i++) begin
			rnd = xs(rnd);
			common_clk_cfg = i[0];
			{dea, deb} = rnd[5:0];
			rd(10'h027, {14'h0000, i[0] ? dea : deb, i[0] ? 3'h3 : 3'h4, 12'hc11}, 1);
		end
		rnd = xs(rnd);
		rd({2'h1, rnd[7:0]}, 32'h0000_0000, 1);
		// Second edge of a held read gets no reply
		rd(10'h026, st(), 2);
		for (int i = 0; i < 4; i++) begin
			rnd = xs(rnd);
			aux_supply_present = rnd[0];
			pulse({2'h0, 4'h1 << i});
			rd(10'h026, st(), 1);
		end
		rnd = xs(rnd);
		wr(4'hb, rnd);
		wr(4'h4, rnd);
		rd(10'h026, st(), 1);
		wr(4'h4, 32'h000f_0000);
		rd(10'h026, st(), 1);
		foreach (np_seq[k]) begin
			pulse(np_seq[k]);
			rd(10'h026, st(), 1);
		end
		repeat (4) @(posedge ref_clk);
		chk(32'(exp_q.size()), 32'h0000_0000);
		results();
	end
endmodule
`default_nettype wire
